// ### hw/lcd_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH
`define CTRL_OFF        8'h00
`define STATUS_OFF      8'h04
`define CMD_OFF         8'h08
`define ADDR_OFF        8'h0C
`define CTRL_BUS8       0
`define CTRL_DUTY_LO    1
`define CTRL_DUTY_HI    2
`define CTRL_TWO_LINE   3
`define CTRL_FONT11     4
`define CTRL_HOLD_BUSY  5
`define CTRL_RESET      6'h01
`define ADDR_GLYPH_SEL  7
`define STATUS_BUSY     7
`define STATUS_PENDING  8
`define CMD_VALID       8
`define CHAR_MEM_DEPTH  80
`define GLYPH_MEM_DEPTH 64
`define SEG_COUNT       40
`define COM_COUNT       16
`define DOTS_PER_LINE   80
`define LINE2_BASE      40
`define CLK_PERIOD_NS   100
`define DOT_PERIOD_NS   400
`define DOT_DIV         (`DOT_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ### hw/lcd_types_pkg.sv
// Types shared by the host port and its word buffer
package lcd_types_pkg;
    typedef enum logic [1:0] {DUTY_8, DUTY_11, DUTY_16} duty_t;
    typedef struct packed {
        logic       rs;
        logic [7:0] value;
    } host_word_t;
endpackage

// ### hw/word_buf_if.sv
// Valid/ready carrier between host port and its two-entry buffer
`timescale 1ns/1ps
interface word_buf_if;
    import lcd_types_pkg::*;
    host_word_t in_data;
    host_word_t out_data;
    logic       in_valid;
    logic       in_ready;
    logic       out_valid;
    logic       out_ready;
    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
    modport user  (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data);
endinterface

// ### hw/two_word_buffer.sv
// Two-entry valid/ready buffer for host bus writes
`timescale 1ns/1ps
module two_word_buffer (
    input wire logic hclk,
    input wire logic hresetn,
    word_buf_if.store port
);
    import lcd_types_pkg::*;

    host_word_t slot [0:1];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign push = port.in_valid & port.in_ready;
    assign pop = port.out_valid & port.out_ready;
    assign port.in_ready = (count != 2'h2);
    assign port.out_valid = (count != 2'h0);
    assign port.out_data = slot[rd_ptr];

    always_ff @(posedge hclk)
    begin
        if (push)
            slot[wr_ptr] <= port.in_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    fill_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
        count <= 2'h2)
        else $error("buffer count above two");
endmodule // two_word_buffer

// ### hw/char_lcd_host_port.sv
// Character display controller: host port, memories and panel scan
// How it works
// RULE1: high selects data, low selects command
// RULE2: direction high reads, low writes
// RULE3: 8-bit mode uses all eight lines
// RULE4: 4-bit mode uses upper four lines only
// RULE5: busy shown on top bus line
// RULE6: extension dot output starts at dot 41
// RULE7: polarity toggle flips every frame
// RULE8: separate latch and shift pulses
// RULE9: duty one eighth, eleventh or sixteenth
// RULE10: sixteen commons, forty segments
// RULE11: one or two lines, 5x8 or 5x11
// RULE12: sixty-four byte user glyph memory
// RULE13: eighty byte character code memory
// RULE14: defined state at power up
// RULE15: status read gives busy and address
// RULE16: host waits while busy reads high
// RULE17: strobe qualifies; falling edge samples
// RULE18: 4-bit bytes go high nibble first
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcd_defines.svh"
module char_lcd_host_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        register_choose_line,
    input  wire logic        rw_select,
    input  wire logic        transfer_strobe,
    input  wire logic [7:0]  host_bus_lines_in,
    output logic      [7:0]  host_bus_lines_out,
    output logic      [7:0]  host_bus_lines_oe,
    output logic             ext_serial_dot,
    output logic             ext_latch_pulse,
    output logic             ext_shift_pulse,
    output logic             polarity_toggle,
    output logic      [15:0] common_scan_outputs,
    output logic      [39:0] segment_outputs
);
    import lcd_types_pkg::*;

    word_buf_if wb();

    two_word_buffer u_buf (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (wb)
    );

    logic        bus8;
    duty_t       duty;
    logic        two_line;
    logic        font11;
    logic        hold_busy;
    logic        glyph_sel;
    logic [6:0]  address_counter;
    logic        busy_indication;
    logic [7:0]  char_code_memory [0:`CHAR_MEM_DEPTH-1];
    logic [7:0]  user_glyph_memory [0:`GLYPH_MEM_DEPTH-1];
    logic [10:0] pin_s1;
    logic [10:0] pin_s2;
    logic        strobe_s3;
    logic        low_phase;
    logic [3:0]  high_nibble;
    logic [7:0]  rd_byte;
    logic        wr_pend;
    logic [3:0]  wr_addr;

    // Maps an address counter value onto the 80-byte code memory
    function automatic logic [6:0] char_index(input logic [6:0] a,
                                              input logic       two);
        if (two)
            char_index = a[6] ? 7'(`LINE2_BASE) + {1'b0, a[5:0]}
                              : {1'b0, a[5:0]};
        else
            char_index = a;
    endfunction

    function automatic logic [4:0] duty_lines(input duty_t d);
        unique case (d)
            DUTY_8:  duty_lines = 5'h08;
            DUTY_11: duty_lines = 5'h0B;
            default: duty_lines = 5'h10;
        endcase
    endfunction

    // Host pins, two flops each before any logic
    logic       rs_s;
    logic       rw_s;
    logic       stb_s;
    logic [7:0] db_s;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1    <= 11'h000;
            pin_s2    <= 11'h000;
            strobe_s3 <= 1'b0;
        end
        else
        begin
            pin_s1 <= {register_choose_line, rw_select, transfer_strobe,
                       host_bus_lines_in};
            pin_s2    <= pin_s1;
            strobe_s3 <= pin_s2[8];
        end
    end
    assign rs_s = pin_s2[10];
    assign rw_s = pin_s2[9];
    assign stb_s = pin_s2[8];
    assign db_s = pin_s2[7:0];

    logic       stb_rise;
    logic       stb_fall;
    logic       byte_done;
    logic       read_step;
    logic [6:0] host_idx;
    logic [7:0] mem_read;
    assign stb_rise = stb_s & ~strobe_s3;
    assign stb_fall = ~stb_s & strobe_s3;
    // RULE18: byte ends on low nibble
    assign byte_done = stb_fall & (bus8 | low_phase);
    // RULE1: choose line picks data or command
    assign read_step = byte_done & rw_s & rs_s;
    assign host_idx = char_index(address_counter, two_line);
    assign mem_read = glyph_sel ? user_glyph_memory[address_counter[5:0]]
                    : (host_idx < 7'(`CHAR_MEM_DEPTH))
                    ? char_code_memory[host_idx] : 8'h00;

    // RULE17: write sampled at falling strobe
    assign wb.in_valid = byte_done & ~rw_s;
    // RULE4: low half arrives on upper lines
    assign wb.in_data = '{rs: rs_s, value: bus8 ? db_s
                                           : {high_nibble, db_s[7:4]}};

    // RULE18: high nibble first, low second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_phase   <= 1'b0;
            high_nibble <= 4'h0;
        end
        else if (bus8)
            low_phase <= 1'b0;
        else if (stb_fall)
        begin
            low_phase <= ~low_phase;
            if (!low_phase)
                high_nibble <= db_s[7:4];
        end
    end

    // RULE15: status byte is busy and address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_byte <= 8'h00;
        else if (stb_rise && rw_s && (bus8 || !low_phase))
            rd_byte <= rs_s ? mem_read : {busy_indication, address_counter};
    end

    // RULE2: drive lines only on reads
    // RULE3: all eight lines in 8-bit mode
    // RULE5: busy lands on top line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_bus_lines_out <= 8'h00;
            host_bus_lines_oe  <= 8'h00;
        end
        else
        begin
            host_bus_lines_out <= bus8 ? rd_byte : low_phase
                                ? {rd_byte[3:0], 4'h0}
                                : {rd_byte[7:4], 4'h0};
            host_bus_lines_oe <= (stb_s && strobe_s3 && rw_s)
                               ? (bus8 ? 8'hFF : 8'hF0) : 8'h00;
        end
    end

    // Commands wait for software; data goes straight to memory
    logic ahb_go;
    logic cmd_pop;
    logic data_drain;
    logic mapped;
    assign ahb_go = hsel & htrans[1] & hready;
    assign mapped = (haddr[31:4] == 28'h0) & (haddr[1:0] == 2'h0);
    assign cmd_pop = ahb_go & ~hwrite & mapped & wb.out_valid
                   & ~wb.out_data.rs & (haddr[7:0] == `CMD_OFF);
    assign wb.out_ready = wb.out_data.rs | cmd_pop;
    assign data_drain = wb.out_valid & wb.out_data.rs;

    // RULE12: glyph bytes written at address
    // RULE13: code bytes written at address
    always_ff @(posedge hclk)
    begin
        if (data_drain)
        begin
            if (glyph_sel)
                user_glyph_memory[address_counter[5:0]] <= wb.out_data.value;
            else if (host_idx < 7'(`CHAR_MEM_DEPTH))
                char_code_memory[host_idx] <= wb.out_data.value;
        end
    end

    // RULE14: all control state has reset values
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            address_counter <= 7'h00;
            glyph_sel       <= 1'b0;
        end
        else if (wr_pend && wr_addr == 4'(`ADDR_OFF))
        begin
            address_counter <= hwdata[6:0];
            glyph_sel       <= hwdata[`ADDR_GLYPH_SEL];
        end
        else if (data_drain || read_step)
            address_counter <= address_counter + 7'h01;
    end

    // RULE16: busy while anything is unconsumed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            busy_indication <= 1'b0;
        else
            busy_indication <= hold_busy | wb.out_valid | wb.in_valid;
    end

    // Zero wait states; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 4'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend <= ahb_go & hwrite & mapped;
            wr_addr <= haddr[3:0];
            hrdata  <= 32'h0;
            if (ahb_go && !hwrite && mapped)
                unique case (haddr[7:0])
                    `CTRL_OFF:   hrdata <= {26'h0, hold_busy, font11,
                                            two_line, duty, bus8};
                    `STATUS_OFF: hrdata <= {23'h0, wb.out_valid,
                                            busy_indication,
                                            address_counter};
                    `CMD_OFF:    hrdata <= {23'h0, cmd_pop,
                                            cmd_pop ? wb.out_data.value
                                                    : 8'h00};
                    default:     hrdata <= {24'h0, glyph_sel,
                                            address_counter};
                endcase
        end
    end

    // RULE9: duty set by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            {hold_busy, font11, two_line, duty, bus8} <= `CTRL_RESET;
        else if (wr_pend && wr_addr == 4'(`CTRL_OFF))
        begin
            bus8      <= hwdata[`CTRL_BUS8];
            duty      <= (hwdata[`CTRL_DUTY_HI:`CTRL_DUTY_LO] == 2'h3)
                       ? DUTY_16
                       : duty_t'(hwdata[`CTRL_DUTY_HI:`CTRL_DUTY_LO]);
            two_line  <= hwdata[`CTRL_TWO_LINE];
            font11    <= hwdata[`CTRL_FONT11];
            hold_busy <= hwdata[`CTRL_HOLD_BUSY];
        end
    end

    // Panel scan: one dot per tick, 80 dots then a latch
    logic [2:0]  div_cnt;
    logic        dot_tick;
    logic [6:0]  col;
    logic [2:0]  sub;
    logic [3:0]  chr;
    logic [3:0]  com;
    logic [39:0] seg_shift;
    logic [3:0]  row;
    logic [7:0]  code;
    logic [7:0]  glyph;
    logic        dot;
    logic        line_end;
    assign dot_tick = (div_cnt == 3'(`DOT_DIV - 1));
    assign line_end = dot_tick & (col == 7'(`DOTS_PER_LINE));
    // RULE11: row source follows lines and font
    assign row = (two_line || !font11) ? {1'b0, com[2:0]} : com;
    assign code = char_code_memory[char_index({two_line & com[3], 2'b00, chr},
                                              two_line)];
    assign glyph = user_glyph_memory[{code[2:0], row[2:0]}];
    assign dot = (row < 4'h8) & glyph[3'h4 - sub];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_cnt <= 3'h0;
        else
            div_cnt <= dot_tick ? 3'h0 : div_cnt + 3'h1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            col       <= 7'h00;
            sub       <= 3'h0;
            chr       <= 4'h0;
            seg_shift <= 40'h0;
        end
        else if (line_end)
        begin
            col <= 7'h00;
            sub <= 3'h0;
            chr <= 4'h0;
        end
        else if (dot_tick)
        begin
            col <= col + 7'h01;
            sub <= (sub == 3'h4) ? 3'h0 : sub + 3'h1;
            chr <= (sub == 3'h4) ? chr + 4'h1 : chr;
            if (col < 7'(`SEG_COUNT))
                seg_shift <= {seg_shift[38:0], dot};
        end
    end

    // RULE6: dots from 41 on go out serially
    // RULE8: shift per serial dot from 41 on, latch per line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_serial_dot  <= 1'b0;
            ext_shift_pulse <= 1'b0;
            ext_latch_pulse <= 1'b0;
        end
        else
        begin
            ext_shift_pulse <= dot_tick & ~line_end
                             & (col >= 7'(`SEG_COUNT));
            ext_latch_pulse <= line_end;
            if (dot_tick && !line_end && col >= 7'(`SEG_COUNT))
                ext_serial_dot <= dot;
        end
    end

    // RULE10: one common per line, forty segments
    // RULE7: toggle at end of each frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            com                 <= 4'h0;
            common_scan_outputs <= 16'h0000;
            segment_outputs     <= 40'h0;
            polarity_toggle     <= 1'b0;
        end
        else if (line_end)
        begin
            segment_outputs     <= seg_shift;
            common_scan_outputs <= 16'h0001 << com;
            if ({1'b0, com} >= duty_lines(duty) - 5'h01)
            begin
                com             <= 4'h0;
                polarity_toggle <= ~polarity_toggle;
            end
            else
                com <= com + 4'h1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence nib_hi_s;
        stb_fall && !bus8 && !low_phase && !rw_s;
    endsequence
    sequence nib_lo_s;
        stb_fall && !bus8 && low_phase && !rw_s;
    endsequence

    route_write_a: assert property (wb.in_valid |->  // RULE1
        wb.in_data.rs == rs_s && !rw_s)
        else $error("write routed with wrong choose line");
    drive_dir_a: assert property (host_bus_lines_oe[7] |->  // RULE2
        $past(rw_s) && $past(stb_s))
        else $error("bus driven without a read");
    low_half_a: assert property (host_bus_lines_oe[0] |-> bus8)  // RULE3
        else $error("low lines driven in 4-bit mode");
    narrow_bus_a: assert property (!bus8 |=>  // RULE4
        host_bus_lines_oe[3:0] == 4'h0 || $past(bus8))
        else $error("low lines driven in 4-bit mode");
    status_byte_a: assert property (stb_rise && rw_s && !rs_s  // RULE15
        && (bus8 || !low_phase) |=>
        rd_byte == {$past(busy_indication), $past(address_counter)})
        else $error("status byte not busy and address");
    busy_hold_a: assert property (wb.out_valid |=> busy_indication)  // RULE16
        else $error("busy low while a word waits");
    nibble_take_a: assert property (nib_hi_s |=>  // RULE18
        low_phase && {4'h0, high_nibble} == ($past(db_s) >> 4))
        else $error("high nibble not held");
    nibble_pair_a: assert property (nib_lo_s |->  // RULE18
        wb.in_valid && wb.in_data.value == {high_nibble, db_s[7:4]})
        else $error("nibble pair assembled wrongly");
    shift_pulse_a: assert property (ext_shift_pulse |=>  // RULE8
        !ext_shift_pulse && !ext_latch_pulse)
        else $error("shift pulse longer than one cycle");
    frame_flip_a: assert property ($changed(polarity_toggle) |->  // RULE7
        ext_latch_pulse)
        else $error("polarity changed away from a line end");
    duty_bound_a: assert property (line_end ##1 $stable(duty)  // RULE9
        |-> {1'b0, com} < duty_lines(duty))
        else $error("common counter beyond duty");
    common_one_a: assert property ($onehot0(common_scan_outputs))  // RULE10
        else $error("more than one common active");
endmodule // char_lcd_host_port

// ### test/host_mpu_model.sv
// Host microprocessor model driving the display's parallel pins
`timescale 1ns/1ps
module host_mpu_model (
    input  wire logic        clk,
    input  wire logic [7:0]  dev_out,
    input  wire logic [7:0]  dev_oe,
    output logic             rs,
    output logic             rw,
    output logic             strobe,
    output logic      [7:0]  pins,
    output logic             rd_valid,
    output logic      [31:0] rd_data
);
    logic [7:0] drv;
    logic [7:0] got;
    logic [7:0] oe_seen;
    logic [7:0] first;

    // No pull-ups: a released line shows the inverse of its last level
    assign pins = (dev_oe & dev_out) | (~dev_oe & drv);

    initial
    begin
        rs       = 1'h0;
        rw       = 1'h0;
        strobe   = 1'h0;
        drv      = 8'h00;
        rd_valid = 1'h0;
        rd_data  = 32'h0;
    end

    // choose and direction held around one strobe
    task automatic pulse(input logic s, input logic r, input logic [7:0] v);
        @(posedge clk);
        rs     <= s;
        rw     <= r;
        drv    <= r ? ~drv : v;
        @(posedge clk);
        strobe <= 1'h1;
        repeat (6) @(posedge clk);
        got     = pins;
        oe_seen = dev_oe;
        strobe <= 1'h0;
        repeat (4) @(posedge clk);
    endtask

    // narrow bus sends high nibble first on lines 7..4
    task automatic xfer(input logic s, input logic r, input logic [7:0] v,
                        input logic bus8, input logic note);
        if (bus8)
            pulse(s, r, v);
        else
        begin
            pulse(s, r, {v[7:4], 4'h5});
            first = got;
            pulse(s, r, {v[3:0], 4'hA});
            got = {first[7:4], got[7:4]};
        end
        if (note)
        begin
            rd_data  <= {16'h0000, oe_seen, got};
            rd_valid <= 1'h1;
            @(posedge clk);
            rd_valid <= 1'h0;
        end
    endtask

    // poll busy before the next transfer
    task automatic wait_idle(input logic bus8);
        int n;
        n = 0;
        do
        begin
            xfer(1'h0, 1'h1, 8'h00, bus8, 1'h0);
            n++;
        end
        while (got[7] !== 1'h0 && n < 40);
    endtask
endmodule // host_mpu_model

// ### test/tb.sv
// Self-checking bench for the character display host port
`timescale 1ns/1ps
`include "lcd_defines.svh"
module tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_data, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        rs, rw, strobe, ext_dot, latch, shift, polarity;
    logic        rd_valid, rd_dphase;
    logic [7:0]  pins, dev_out, dev_oe, c0, c1, c2, d;
    logic [15:0] com;
    logic [39:0] seg;
    logic [31:0] exp_q[$];
    int          n_fail, compares, cycles, seed;

    char_lcd_host_port DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .register_choose_line(rs), .rw_select(rw),
        .transfer_strobe(strobe), .host_bus_lines_in(pins),
        .host_bus_lines_out(dev_out), .host_bus_lines_oe(dev_oe),
        .ext_serial_dot(ext_dot), .ext_latch_pulse(latch),
        .ext_shift_pulse(shift), .polarity_toggle(polarity),
        .common_scan_outputs(com), .segment_outputs(seg)
    );

    host_mpu_model host (
        .clk(hclk), .dev_out(dev_out), .dev_oe(dev_oe), .rs(rs), .rw(rw),
        .strobe(strobe), .pins(pins), .rd_valid(rd_valid),
        .rd_data(rd_data)
    );

    initial
    begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Reads note their expectation; the watcher below compares
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] val);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wr ? val : 32'h0;
        if (!wr)
        begin
            exp_q.push_back(val);
            rd_dphase <= 1'h1;
        end
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd_dphase <= 1'h0;
    endtask

    // Latch and shift pulses counted between two polarity flips
    task automatic frame(input int lines);
        int   n;
        int   s;
        logic p;
        p = polarity;
        @(negedge hclk);
        while (polarity === p) @(negedge hclk);
        p = polarity;
        n = 0;
        s = 0;
        do
        begin
            @(negedge hclk);
            n += (latch === 1'h1);
            s += (shift === 1'h1);
        end
        while (polarity === p);
        check(n, lines);
        check(s, 40 * lines);
    endtask

    always @(negedge hclk)
    begin
        if (rd_dphase)
            check(hrdata, exp_q.pop_front());
        if (rd_valid)
            check(rd_data, exp_q.pop_front());
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_fail++;
            end_sim();
        end
    end

    initial
    begin
        seed = 32'h2d573441;
        hresetn = 1'h0;
        {hsel, hwrite, rd_dphase} = 3'h0;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        {n_fail, compares, cycles} = 96'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        check({30'h0, hreadyout, hresp}, 32'h2);
        ahb(1'h0, `CTRL_OFF, 32'h01);
        ahb(1'h0, `STATUS_OFF, 32'h0);
        ahb(1'h1, 8'h10, 32'hFF);
        ahb(1'h0, 8'h10, 32'h0);
        ahb(1'h0, `CTRL_OFF, 32'h01);
        $display("test done: reset and unmapped");
        c0 = $random(seed);
        c1 = $random(seed);
        c2 = $random(seed);
        host.xfer(1'h0, 1'h0, c0, 1'h1, 1'h0);
        host.xfer(1'h0, 1'h0, c1, 1'h1, 1'h0);
        host.xfer(1'h0, 1'h0, c2, 1'h1, 1'h0);
        ahb(1'h0, `STATUS_OFF, 32'h180);
        ahb(1'h0, `CMD_OFF, {23'h0, 1'h1, c0});
        ahb(1'h0, `CMD_OFF, {23'h0, 1'h1, c1});
        ahb(1'h0, `CMD_OFF, 32'h0);
        ahb(1'h0, `STATUS_OFF, 32'h0);
        $display("test done: command buffer");
        ahb(1'h1, `ADDR_OFF, 32'h25);
        exp_q.push_back(32'hFF25);
        host.xfer(1'h0, 1'h1, 8'h00, 1'h1, 1'h1);
        ahb(1'h1, `CTRL_OFF, 32'h21);
        exp_q.push_back(32'hFFA5);
        host.xfer(1'h0, 1'h1, 8'h00, 1'h1, 1'h1);
        ahb(1'h1, `CTRL_OFF, 32'h01);
        $display("test done: status read");
        d = $random(seed);
        ahb(1'h1, `ADDR_OFF, 32'h03);
        host.xfer(1'h1, 1'h0, d, 1'h1, 1'h0);
        host.wait_idle(1'h1);
        ahb(1'h0, `STATUS_OFF, 32'h04);
        ahb(1'h1, `ADDR_OFF, 32'h03);
        exp_q.push_back({16'h00FF, d});
        host.xfer(1'h1, 1'h1, 8'h00, 1'h1, 1'h1);
        ahb(1'h0, `ADDR_OFF, 32'h04);
        ahb(1'h1, `ADDR_OFF, 32'hBF);
        host.xfer(1'h1, 1'h0, ~d, 1'h1, 1'h0);
        host.wait_idle(1'h1);
        ahb(1'h1, `ADDR_OFF, 32'hBF);
        exp_q.push_back({16'h00FF, ~d});
        host.xfer(1'h1, 1'h1, 8'h00, 1'h1, 1'h1);
        $display("test done: memories");
        ahb(1'h1, `CTRL_OFF, 32'h00);
        host.xfer(1'h0, 1'h0, c2, 1'h0, 1'h0);
        ahb(1'h0, `CMD_OFF, {23'h0, 1'h1, c2});
        ahb(1'h1, `ADDR_OFF, 32'h5A);
        exp_q.push_back(32'hF05A);
        host.xfer(1'h0, 1'h1, 8'h00, 1'h0, 1'h1);
        $display("test done: four-bit bus");
        for (int i = 0; i < 4; i++)
        begin
            v = 32'h1 | (i << 1) | ($random(seed) & 32'h18);
            ahb(1'h1, `CTRL_OFF, v);
            ahb(1'h0, `CTRL_OFF, (v & ~32'h6) | ((i > 2 ? 2 : i) << 1));
            if (i < 3)
                frame(i == 0 ? 8 : (i == 1 ? 11 : 16));
        end
        check({31'h0, $onehot(com)}, 32'h1);
        $display("test done: scan and duty");
        // One glyph dot per cell, all codes zero: known panel pattern
        ahb(1'h1, `CTRL_OFF, 32'h01);
        ahb(1'h1, `ADDR_OFF, 32'h80);
        for (int i = 0; i < 144; i++)
        begin
            if (i == 64)
                ahb(1'h1, `ADDR_OFF, 32'h00);
            host.xfer(1'h1, 1'h0, (i < 64) ? 8'h10 : 8'h00, 1'h1, 1'h0);
        end
        repeat (2) @(posedge latch);
        @(negedge hclk);
        check({24'h0, seg[39:32]}, 32'h84);
        check(seg[31:0], 32'h21084210);
        @(negedge hclk iff shift === 1'h1);
        check({31'h0, ext_dot}, 32'h1);
        $display("test done: panel data");
        end_sim();
    end
endmodule // tb
